// file: gamrs_serial_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - A memory word with one failed bit is corrected before loading the channel
// - A word with two failed bits loads the channel default instead
// - Pointer 111101 reads back a fixed 16-bit part identification code
// - Pointer 111100 reads the silicon revision, counting upward from the first
// - Data bits 15:14 equal to 01 select memory, anything else the register
// - Pointers 000000 to 000111 are gamma levels, 010010 the common voltage
// - The pointer steps from 000111 straight to 010010
// - Words arrive high byte first; bits 9:0 are level; commit on second byte
// - STOP or START before a word completes leaves the register untouched
// - Every received write data byte is acknowledged
// - Writing a level register does not move its output by itself
// - Multi writes take 19 slots, discard sets nine to eighteen, 19th is common
// - The write-disable bit changes only through a single-register write
// - Reads accept level pointers and 111100 to 111111, high byte first
// - Upper six bits of a read-back level word carry no data
// - Multi read: master acknowledges every byte, device keeps supplying words
// - A read stops at once on STOP, START or a missing acknowledge
// - Identification, revision and write count are served only as single reads
// - Direction bit zero starts a write, one starts a read
// - Data bit 15 set copies all level registers to the outputs
// - Pointer 111111 reads the memory write count code of the bank
// - A word with top bits 01 requests a memory write for the channel while write-disable is clear
module gamrs_serial_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h4a,
   // Arbitrary value
   parameter logic [15:0] PART_ID = 16'h5a3c,
   // Arbitrary value
   parameter logic [15:0] SILICON_REV = 16'h0007,
   parameter int DISCARD_SLOTS = gamrs_pkg::GAMRS_DISCARD_SLOTS
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic scl_pin,
   input wire logic sda_pin_in,
   output logic sda_pin_out,
   output logic sda_pin_oe_n,
   input wire gamrs_pkg::gamrs_acq_t acq,
   input wire logic [3:0] write_count_code,
   output gamrs_pkg::gamrs_levels_t level,
   output gamrs_pkg::gamrs_levels_t dac_out,
   output gamrs_pkg::gamrs_nvm_wr_t nvm_wr,
   output logic wr_disable
);
   import gamrs_pkg::*;

   // ************************************************************
   // Pointer decoding
   // ************************************************************
   function automatic logic [3:0] chan_of(input logic [5:0] a);
      if (a <= GAMRS_ADDR_GAMMA_LAST)
         return {1'b0, a[2:0]};
      return (a == GAMRS_ADDR_COMMON_VOLTAGE_LEVEL) ? GAMRS_IDX_COMMON_VOLTAGE_LEVEL : GAMRS_IDX_NONE;
   endfunction

   function automatic logic [5:0] next_addr(input logic [5:0] a);
      if (a < GAMRS_ADDR_GAMMA_LAST)
         return a + 6'h01;
      return (a == GAMRS_ADDR_GAMMA_LAST) ? GAMRS_ADDR_COMMON_VOLTAGE_LEVEL : GAMRS_ADDR_NONE;
   endfunction

   function automatic logic ptr_ok(input logic [7:0] b);
      return (b[7:6] == 2'h0) && ((chan_of(b[5:0]) != GAMRS_IDX_NONE)
             || (b[5:0] >= GAMRS_ADDR_REV));
   endfunction

   function automatic logic [15:0] rd_word(input logic [5:0] a, input logic later,
                                           input gamrs_levels_t lv, input logic [3:0] wc);
      if (chan_of(a) != GAMRS_IDX_NONE)
         return {6'h00, lv[chan_of(a)]};
      if (later)
         return GAMRS_RD_EMPTY;
      case (a)
         GAMRS_ADDR_ID: return PART_ID;
         GAMRS_ADDR_REV: return SILICON_REV;
         GAMRS_ADDR_WCOUNT: return {12'h000, wc};
         default: return GAMRS_RD_EMPTY;
      endcase
   endfunction

   // ************************************************************
   // Pin synchronisers and bus conditions
   // ************************************************************
   logic [2:0] scl_sy;
   logic [2:0] sda_sy;
   logic scl_q;
   logic sda_q;
   logic scl_prev;
   logic sda_prev;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         scl_sy <= 3'h7;
         sda_sy <= 3'h7;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end
      else
      begin
         scl_sy <= {scl_sy[1:0], scl_pin};
         sda_sy <= {sda_sy[1:0], sda_pin_in};
         if (scl_sy[1] == scl_sy[2])
            scl_q <= scl_sy[2];
         if (sda_sy[1] == sda_sy[2])
            sda_q <= sda_sy[2];
         scl_prev <= scl_q;
         sda_prev <= sda_q;
      end
   end

   wire scl_rise = scl_q & ~scl_prev;
   wire scl_fall = ~scl_q & scl_prev;
   wire start_det = scl_q & scl_prev & sda_prev & ~sda_q;
   wire stop_det = scl_q & scl_prev & ~sda_prev & sda_q;

   // ************************************************************
   // Transaction state
   // ************************************************************
   gamrs_state_t state;
   gamrs_state_t ack_to;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic [7:0] hi_byte;
   logic got_hi;
   logic [7:0] tx_sh;
   logic byte_sel;
   logic rd_later;
   logic mack;
   logic [5:0] ptr;
   logic [4:0] slot_cnt;
   logic first_word;
   logic pend_v;
   logic pend_wd;
   gamrs_levels_t next_level;

   wire byte_end = scl_fall && (bit_cnt == GAMRS_BYTE_BITS);
   wire wdata_end = byte_end && (state == S_WDAT);
   wire commit = wdata_end && got_hi;
   wire [15:0] wr_word = {hi_byte, shreg};
   wire [3:0] cur_idx = chan_of(ptr);
   wire discard = (slot_cnt != 5'h00) || (cur_idx == GAMRS_IDX_NONE);
   wire nvm_sel = (wr_word[15:14] == GAMRS_SEL_NVM);
   wire vol_wr = commit && !discard && !nvm_sel;
   wire nvm_go = commit && !discard && nvm_sel && !wr_disable;
   wire latch_go = vol_wr && wr_word[GAMRS_LATCH_BIT];
   wire addr_hit = (shreg[7:1] == DEV_ADDR);
   wire [15:0] rd_cur = rd_word(ptr, rd_later, level, write_count_code);
   wire [15:0] rd_next = rd_word(next_addr(ptr), 1'b1, level, write_count_code);
   wire acq_go = acq.valid && (acq.chan < GAMRS_IDX_NONE);
   wire [10:0] acq_fix = gamrs_ecc_fix(acq.code);
   wire [9:0] acq_data = acq_fix[9:0];

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state <= S_IDLE;
         ack_to <= S_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         hi_byte <= 8'h00;
         got_hi <= 1'b0;
         tx_sh <= 8'h00;
         byte_sel <= 1'b0;
         rd_later <= 1'b0;
         mack <= 1'b0;
         ptr <= GAMRS_PTR_RESET;
         slot_cnt <= 5'h00;
         first_word <= 1'b1;
         pend_v <= 1'b0;
         pend_wd <= 1'b0;
         wr_disable <= 1'b0;
         sda_pin_oe_n <= 1'b1;
      end
      else if (start_det || stop_det)
      begin
         state <= start_det ? S_ADDR : S_IDLE;
         bit_cnt <= 4'h0;
         got_hi <= 1'b0;
         sda_pin_oe_n <= 1'b1;
         pend_v <= 1'b0;
         if (pend_v)
            wr_disable <= pend_wd;
      end
      else
      begin
         case (state)
            S_ADDR, S_PTR, S_WDAT:
            begin
               if (scl_rise && (bit_cnt != GAMRS_BYTE_BITS))
               begin
                  shreg <= {shreg[6:0], sda_q};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               else if (byte_end)
               begin
                  bit_cnt <= 4'h0;
                  rd_later <= 1'b0;
                  state <= S_ACK;
                  sda_pin_oe_n <= 1'b0;
                  ack_to <= S_WDAT;
                  if (state == S_ADDR)
                  begin
                     ack_to <= shreg[0] ? S_RDAT : S_PTR;
                     if (!addr_hit)
                     begin
                        state <= S_IDLE;
                        sda_pin_oe_n <= 1'b1;
                     end
                  end
                  else if (state == S_PTR)
                  begin
                     if (ptr_ok(shreg))
                     begin
                        ptr <= shreg[5:0];
                        slot_cnt <= 5'h00;
                        first_word <= 1'b1;
                        got_hi <= 1'b0;
                     end
                     else
                     begin
                        state <= S_IDLE;
                        sda_pin_oe_n <= 1'b1;
                     end
                  end
                  else if (!got_hi)
                  begin
                     hi_byte <= shreg;
                     got_hi <= 1'b1;
                  end
                  else
                  begin
                     got_hi <= 1'b0;
                     first_word <= 1'b0;
                     pend_v <= first_word && !discard && !nvm_sel;
                     pend_wd <= wr_word[GAMRS_WD_BIT];
                     if (slot_cnt != 5'h00)
                        slot_cnt <= slot_cnt - 5'h01;
                     else
                     begin
                        ptr <= next_addr(ptr);
                        if ((ptr == GAMRS_ADDR_GAMMA_LAST) && (DISCARD_SLOTS > 0))
                           slot_cnt <= 5'(DISCARD_SLOTS);
                     end
                  end
               end
            end
            S_ACK:
            begin
               if (scl_fall)
               begin
                  bit_cnt <= 4'h0;
                  state <= ack_to;
                  byte_sel <= 1'b0;
                  if (ack_to == S_RDAT)
                  begin
                     sda_pin_oe_n <= rd_cur[15];
                     tx_sh <= {rd_cur[14:8], 1'b0};
                  end
                  else
                     sda_pin_oe_n <= 1'b1;
               end
            end
            S_RDAT:
            begin
               if (scl_rise)
                  bit_cnt <= bit_cnt + 4'h1;
               else if (byte_end)
               begin
                  sda_pin_oe_n <= 1'b1;
                  state <= S_RACK;
               end
               else if (scl_fall)
               begin
                  sda_pin_oe_n <= tx_sh[7];
                  tx_sh <= {tx_sh[6:0], 1'b0};
               end
            end
            S_RACK:
            begin
               if (scl_rise)
                  mack <= ~sda_q;
               else if (scl_fall && !mack)
                  state <= S_IDLE;
               else if (scl_fall)
               begin
                  bit_cnt <= 4'h0;
                  state <= S_RDAT;
                  byte_sel <= ~byte_sel;
                  if (!byte_sel)
                  begin
                     sda_pin_oe_n <= rd_cur[7];
                     tx_sh <= {rd_cur[6:0], 1'b0};
                  end
                  else
                  begin
                     ptr <= next_addr(ptr);
                     rd_later <= 1'b1;
                     sda_pin_oe_n <= rd_next[15];
                     tx_sh <= {rd_next[14:8], 1'b0};
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // ************************************************************
   // Level registers, output latch and memory requests
   // ************************************************************
   always_comb
   begin
      next_level = level;
      if (vol_wr)
         next_level[cur_idx] = wr_word[9:0];
      if (acq_go)
         next_level[acq.chan] = acq_data;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         level <= {GAMRS_NUM_CH{GAMRS_LEVEL_DEFAULT}};
         dac_out <= {GAMRS_NUM_CH{GAMRS_LEVEL_DEFAULT}};
         nvm_wr <= '0;
         sda_pin_out <= 1'b0;
      end
      else
      begin
         level <= next_level;
         if (latch_go)
            dac_out <= next_level;
         else if (acq_go)
            dac_out[acq.chan] <= acq_data;
         nvm_wr.req <= nvm_go;
         nvm_wr.chan <= cur_idx;
         nvm_wr.word <= wr_word;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence s_ack_low;
      !sda_pin_oe_n && (state == S_ACK);
   endsequence

   sequence s_released_idle;
      sda_pin_oe_n && (state == S_IDLE);
   endsequence

   property p_ecc_single;
      acq_go && !acq_fix[10] |=> level[$past(acq.chan)] == $past(acq_fix[9:0]);
   endproperty
   a_ecc_single: assert property (p_ecc_single) else $error("corrected word not loaded");

   property p_ecc_multi;
      acq_go && acq_fix[10] |=> level[$past(acq.chan)] == GAMRS_LEVEL_DEFAULT;
   endproperty
   a_ecc_multi: assert property (p_ecc_multi) else $error("default not loaded");

   property p_part_id;
      (state == S_ACK) && (ack_to == S_RDAT) && scl_fall && (ptr == GAMRS_ADDR_ID)
         |=> (sda_pin_oe_n == PART_ID[15]) && (tx_sh[7:1] == PART_ID[14:8]);
   endproperty
   a_part_id: assert property (p_part_id) else $error("wrong identification byte");

   property p_wrap;
      commit && (ptr == GAMRS_ADDR_GAMMA_LAST) && (slot_cnt == 5'h00) |=> ptr == GAMRS_ADDR_COMMON_VOLTAGE_LEVEL;
   endproperty
   a_wrap: assert property (p_wrap) else $error("pointer did not step to common");

   property p_partial;
      got_hi && (start_det || stop_det) && !acq_go |=> $stable(level);
   endproperty
   a_partial: assert property (p_partial) else $error("partial word committed");

   property p_wr_ack;
      wdata_end |=> s_ack_low ##1 (!sda_pin_oe_n || !scl_fall);
   endproperty
   a_wr_ack: assert property (p_wr_ack) else $error("data byte not acknowledged");

   property p_hold;
      vol_wr && !wr_word[GAMRS_LATCH_BIT] && !acq_go |=> $stable(dac_out);
   endproperty
   a_hold: assert property (p_hold) else $error("output moved without latch bit");

   property p_latch;
      latch_go |=> dac_out == level;
   endproperty
   a_latch: assert property (p_latch) else $error("outputs not latched");

   property p_nack_ptr;
      byte_end && (state == S_PTR) && !ptr_ok(shreg) |=> s_released_idle ##1 $stable(ptr);
   endproperty
   a_nack_ptr: assert property (p_nack_ptr) else $error("bad pointer acknowledged");

   property p_rd_abort;
      (state == S_RACK) && scl_fall && !mack && !start_det && !stop_det |=> s_released_idle;
   endproperty
   a_rd_abort: assert property (p_rd_abort) else $error("read not abandoned");

   property p_nvm;
      nvm_go |=> nvm_wr.req && (nvm_wr.word[15:14] == GAMRS_SEL_NVM);
   endproperty
   a_nvm: assert property (p_nvm) else $error("memory write not requested");

endmodule // gamrs_serial_regs

// file: gamrs_pkg.sv
package gamrs_pkg;

   // ************************************************************
   // Register pointers
   // ************************************************************
   localparam logic [5:0] GAMRS_ADDR_GAMMA_FIRST = 6'h00;
   localparam logic [5:0] GAMRS_ADDR_GAMMA_LAST = 6'h07;
   localparam logic [5:0] GAMRS_ADDR_COMMON_VOLTAGE_LEVEL = 6'h12;
   localparam logic [5:0] GAMRS_ADDR_REV = 6'h3c;
   localparam logic [5:0] GAMRS_ADDR_ID = 6'h3d;
   localparam logic [5:0] GAMRS_ADDR_NONE = 6'h3e;
   localparam logic [5:0] GAMRS_ADDR_WCOUNT = 6'h3f;
   localparam logic [5:0] GAMRS_PTR_RESET = 6'h00;

   // ************************************************************
   // Field layout and values
   // ************************************************************
   localparam int GAMRS_NUM_CH = 9;
   localparam logic [3:0] GAMRS_IDX_COMMON_VOLTAGE_LEVEL = 4'h8;
   localparam logic [3:0] GAMRS_IDX_NONE = 4'h9;
   localparam logic [9:0] GAMRS_LEVEL_DEFAULT = 10'h200;
   localparam logic [1:0] GAMRS_SEL_NVM = 2'h1;
   localparam int GAMRS_LATCH_BIT = 15;
   localparam int GAMRS_WD_BIT = 13;
   localparam logic [15:0] GAMRS_RD_EMPTY = 16'hffff;
   localparam logic [3:0] GAMRS_BYTE_BITS = 4'h8;
   localparam int GAMRS_DISCARD_SLOTS = 10;
   localparam int GAMRS_CODE_PAR_BIT = 14;

   // Check-bit column of each data bit in the stored memory word
   localparam logic [3:0] GAMRS_ECC_COL [10] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h9,
                                                 4'ha, 4'hb, 4'hc, 4'hd, 4'he};

   // ************************************************************
   // Types
   // ************************************************************
   typedef logic [8:0][9:0] gamrs_levels_t;

   typedef struct packed {
      logic valid;
      logic [3:0] chan;
      logic [14:0] code;
   } gamrs_acq_t;

   typedef struct packed {
      logic req;
      logic [3:0] chan;
      logic [15:0] word;
   } gamrs_nvm_wr_t;

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_ADDR = 7'h02,
      S_PTR = 7'h04,
      S_WDAT = 7'h08,
      S_ACK = 7'h10,
      S_RDAT = 7'h20,
      S_RACK = 7'h40
   } gamrs_state_t;

   // ************************************************************
   // Error correction of a stored word: bit 10 flags uncorrectable
   // ************************************************************
   function automatic logic [3:0] gamrs_ecc_chk(input logic [9:0] d);
      logic [3:0] c;
      c = 4'h0;
      for (int i = 0; i < 10; i++)
         if (d[i])
            c = c ^ GAMRS_ECC_COL[i];
      return c;
   endfunction

   function automatic logic [10:0] gamrs_ecc_fix(input logic [14:0] code);
      logic [3:0] syn;
      logic [9:0] d;
      logic hit;
      d = code[9:0];
      syn = gamrs_ecc_chk(code[9:0]) ^ code[13:10];
      hit = 1'b0;
      for (int i = 0; i < 10; i++)
         if (GAMRS_ECC_COL[i] == syn)
         begin
            d[i] = ~d[i];
            hit = 1'b1;
         end
      if (!(^code))
         return (syn == 4'h0) ? {1'b0, code[9:0]} : {1'b1, GAMRS_LEVEL_DEFAULT};
      if ((syn & (syn - 4'h1)) == 4'h0)
         return {1'b0, code[9:0]};
      return hit ? {1'b0, d} : {1'b1, GAMRS_LEVEL_DEFAULT};
   endfunction

endpackage

// file: gamrs_bus_master.sv
`timescale 1ns/1ps
// ************************************************************
// Two-wire bus master model, released SDA reads as pulled up
// ************************************************************
module gamrs_bus_master (
   input wire logic clk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_out
);
   initial
   begin
      scl = 1'b1;
      sda_out = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Long low phase lets the device release SDA before the next bit
   task automatic bit_io(input logic b, output logic r);
      scl <= 1'b0;
      tick(4);
      sda_out <= b;
      tick(4);
      scl <= 1'b1;
      tick(4);
      r = sda_in;
   endtask

   task automatic start();
      scl <= 1'b0;
      tick(4);
      sda_out <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_out <= 1'b0;
      tick(4);
   endtask

   task automatic stop();
      scl <= 1'b0;
      tick(4);
      sda_out <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_out <= 1'b1;
      tick(8);
   endtask

   task automatic wbyte(input logic [7:0] d, output logic acked);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      acked = ~r;
   endtask

   task automatic rbyte(output logic [7:0] d, input logic ack_it);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(~ack_it, r);
   endtask
endmodule // gamrs_bus_master

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import gamrs_pkg::*;
   localparam logic [6:0] ADDR = 7'h4a;
   // Arbitrary value
   localparam logic [15:0] P_ID = 16'h3c5a;
   // Arbitrary value
   localparam logic [15:0] P_REV = 16'h0002;
   logic clk;
   logic srst;
   logic scl;
   logic m_sda;
   logic sda_out;
   logic sda_oe_n;
   wire logic sda_w;
   gamrs_acq_t acq;
   logic [3:0] wcc;
   gamrs_levels_t level;
   gamrs_levels_t dac_out;
   gamrs_nvm_wr_t nvm_wr;
   logic wr_disable;
   int miscompares;
   int checks;
   int nvm_hits;
   logic [15:0] nvm_word;
   logic ack;
   logic [15:0] ws [$];

   assign sda_w = m_sda & (sda_oe_n | sda_out);

   gamrs_serial_regs #(.DEV_ADDR(ADDR), .PART_ID(P_ID), .SILICON_REV(P_REV)) dut_u (
      .clk(clk), .srst(srst), .scl_pin(scl), .sda_pin_in(sda_w),
      .sda_pin_out(sda_out), .sda_pin_oe_n(sda_oe_n), .acq(acq),
      .write_count_code(wcc), .level(level), .dac_out(dac_out),
      .nvm_wr(nvm_wr), .wr_disable(wr_disable));

   gamrs_bus_master bm_u (.clk(clk), .sda_in(sda_w), .scl(scl), .sda_out(m_sda));

   // Memory write requests are one-cycle pulses
   always @(posedge clk)
      if (nvm_wr.req === 1'b1)
      begin
         nvm_hits <= nvm_hits + 1;
         nvm_word <= nvm_wr.word;
      end

   // ************************************************************
   // Checking and bus tasks
   // ************************************************************
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("Counts: %0d checks, %0d miscompares", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic head(input logic [7:0] ptr, output logic ok);
      bm_u.start();
      bm_u.wbyte({ADDR, 1'b0}, ack);
      check("write addr ack", {15'h0, ack}, 16'h0001);
      bm_u.wbyte(ptr, ok);
   endtask

   task automatic write_words(input logic [5:0] ptr, input logic [15:0] w [$]);
      head({2'b00, ptr}, ack);
      check("ptr ack", {15'h0, ack}, 16'h0001);
      foreach (w[i])
      begin
         bm_u.wbyte(w[i][15:8], ack);
         check("hi ack", {15'h0, ack}, 16'h0001);
         bm_u.wbyte(w[i][7:0], ack);
         check("lo ack", {15'h0, ack}, 16'h0001);
      end
      bm_u.stop();
   endtask

   task automatic read_check(input logic [5:0] ptr, input logic [15:0] e [$]);
      logic [7:0] hi;
      logic [7:0] lo;
      head({2'b00, ptr}, ack);
      bm_u.start();
      bm_u.wbyte({ADDR, 1'b1}, ack);
      check("read addr ack", {15'h0, ack}, 16'h0001);
      foreach (e[i])
      begin
         bm_u.rbyte(hi, 1'b1);
         bm_u.rbyte(lo, i != e.size() - 1);
         check("read word", {hi, lo}, e[i]);
      end
      bm_u.stop();
   endtask

   function automatic logic [14:0] enc(input logic [9:0] d);
      logic [3:0] c;
      c = 4'h0;
      for (int i = 0; i < 10; i++)
         if (d[i])
            c = c ^ GAMRS_ECC_COL[i];
      return {^{c, d}, c, d};
   endfunction

   task automatic acquire(input logic [14:0] code);
      @(posedge clk);
      acq <= '{valid: 1'b1, chan: 4'h5, code: code};
      @(posedge clk);
      acq <= '0;
      repeat (3) @(posedge clk);
   endtask

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial
   begin
      #800000;
      miscompares++;
      close_out();
   end

   // ************************************************************
   // Tests
   // ************************************************************
   initial
   begin
      srst = 1'b1;
      acq = '0;
      wcc = 4'h9;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      write_words(6'h03, '{16'h0155});
      check("level 3", {6'h0, level[3]}, 16'h0155);
      check("output 3 held", {6'h0, dac_out[3]}, 16'h0200);
      $display("Test single write done");
      head(8'h02, ack);
      bm_u.wbyte(8'h01, ack);
      bm_u.stop();
      check("aborted level 2", {6'h0, level[2]}, 16'h0200);
      head(8'h20, ack);
      bm_u.stop();
      check("bad ptr ack", {15'h0, ack}, 16'h0000);
      $display("Test abort done");
      write_words(6'h01, '{16'h4123});
      check("memory word level", {6'h0, level[1]}, 16'h0200);
      check("memory requests", 16'(nvm_hits), 16'h0001);
      check("memory word", nvm_word, 16'h4123);
      $display("Test memory write done");
      for (int i = 0; i < 19; i++)
         ws.push_back(16'h2000 | 16'(i * 16'h0021 + 16'h0010));
      ws[18] = 16'ha3c5;
      write_words(6'h00, ws);
      for (int i = 0; i < 8; i++)
         check("multi level", {6'h0, level[i]}, ws[i] & 16'h03ff);
      check("common level", {6'h0, level[8]}, 16'h03c5);
      for (int i = 0; i < 9; i++)
         check("latched out", {6'h0, dac_out[i]}, ws[i == 8 ? 18 : i] & 16'h03ff);
      check("disable kept", {15'h0, wr_disable}, 16'h0000);
      $display("Test multi write done");
      read_check(6'h07, '{ws[7] & 16'h03ff, 16'h03c5, 16'hffff});
      read_check(6'h3d, '{P_ID});
      read_check(6'h3c, '{P_REV, 16'hffff});
      read_check(6'h3f, '{16'h0009});
      read_check(6'h03, '{ws[3] & 16'h03ff});
      $display("Test reads done");
      write_words(6'h04, '{16'h2011});
      check("level 4", {6'h0, level[4]}, 16'h0011);
      check("disable set", {15'h0, wr_disable}, 16'h0001);
      $display("Test write disable done");
      acquire(enc(10'h2a5) ^ 15'h0010);
      check("corrected level", {6'h0, level[5]}, 16'h02a5);
      acquire(enc(10'h0f3) ^ 15'h0011);
      check("default level", {6'h0, level[5]}, 16'h0200);
      $display("Test acquire done");
      close_out();
   end
endmodule // tb_top
